// *** verilog/encoder_pulse_output_divider.sv ***
// encoder pulse output divider: scales motor encoder steps to a/b quadrature pulses
//
// How it works
// - a/b outputs count set by pulse setting
// - setting counts edges; pulses are one quarter
// - mode 0: setting is edges per revolution
// - mode 1: resolution divided by setting
// - reset: setting 4000, direct mode
//
// motion arrives as one-cycle encoder steps with a direction level. a signed
// accumulator spreads output edges evenly over the encoder steps, so each
// quadrature edge stands for a fixed share of a revolution.
`timescale 1ns/100ps
`include "enc_out_regs.svh"
module encoder_pulse_output_divider (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// motor encoder motion, same clock domain
	input wire logic enc_step,
	input wire logic enc_dir_rev,
	// quadrature pulse outputs
	output enc_out_pkg::quad_t enc_out
);
	import enc_out_pkg::*;

	// register state
	logic [15:0] setting_q; // encoder output pulse setting
	logic [15:0] setting_d;
	out_mode_t mode_q; // output mode
	out_mode_t mode_d;
	logic [15:0] edge_cnt_q; // signed count of output edges emitted
	logic [15:0] edge_cnt_d;

	// bus slave state
	logic wait_q; // waitrequest, high until the answer cycle
	logic wait_d;
	logic [31:0] rdata_q; // read data held for the answer cycle
	logic [31:0] rdata_d;

	// accumulator state
	logic signed [23:0] acc_q; // output motion not yet emitted
	logic signed [23:0] acc_d;
	edge_req_t step_q; // edge request, registered toward the generator
	edge_req_t step_d;

	// combinational helpers
	bus_req_t req; // bundled bus request
	logic do_write; // write taken at this edge
	logic cfg_write; // a write that changes the scaling
	logic signed [23:0] inc; // accumulator share per encoder step
	logic signed [23:0] thr; // accumulator share per output edge
	logic signed [23:0] sum; // accumulator after this cycle's step
	quad_t phase; // phase pair from the generator

	// share added per encoder step in each mode
	function automatic logic signed [23:0] step_share(input out_mode_t m,
			input logic [15:0] s);
		logic signed [23:0] r;
		r = 24'sh00_0001;
		if (m == mode_direct) begin
			r = signed'({8'h00, s});
		end
		return r;
	endfunction

	// share that one output edge consumes in each mode
	function automatic logic signed [23:0] edge_share(input out_mode_t m,
			input logic [15:0] s);
		logic signed [23:0] r;
		r = signed'(`ENC_RESOLUTION);
		if (m == mode_divide) begin
			// a zero divisor would emit an edge every cycle; it is treated as one
			if (s == 16'h0000) begin
				r = 24'sh00_0001;
			end else begin
				r = signed'({8'h00, s});
			end
		end
		return r;
	endfunction

	// decode of a register word from the bus address
	function automatic logic [31:0] read_word(input logic [3:0] a,
			input logic [15:0] s, input out_mode_t m, input quad_t p,
			input logic [15:0] c);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (a == `ENC_OFS_PULSE_SETTING) begin
			w = {16'h0000, s};
		end else if (a == `ENC_OFS_CONTROL) begin
			w = {31'h0000_0000, m};
		end else if (a == `ENC_OFS_STATUS) begin
			w = {30'h0000_0000, p.b, p.a};
		end else if (a == `ENC_OFS_EDGE_COUNT) begin
			w = {16'h0000, c};
		end
		return w;
	endfunction

	// bundle the bus signals
	always_comb begin
		req.addr = avs_address;
		req.rd = avs_read;
		req.wr = avs_write;
		req.wdata = avs_writedata;
	end

	// a write takes effect at the edge where waitrequest is seen low
	assign do_write = req.wr && !wait_q;

	// scaling changes restart the accumulator so stale fractions do not leak
	always_comb begin
		cfg_write = 1'b0;
		if (do_write) begin
			if (req.addr == `ENC_OFS_PULSE_SETTING) begin
				cfg_write = 1'b1;
			end else if (req.addr == `ENC_OFS_CONTROL) begin
				cfg_write = 1'b1;
			end
		end
	end

	// bus slave: one wait cycle, then one answer cycle
	always_comb begin
		wait_d = 1'b1;
		rdata_d = rdata_q;
		if ((req.rd || req.wr) && wait_q) begin
			// first cycle of a request: prepare the answer
			wait_d = 1'b0;
			if (req.rd) begin
				rdata_d = read_word(req.addr, setting_q, mode_q, phase, edge_cnt_q);
			end
		end
	end

	// configuration registers written by software
	always_comb begin
		setting_d = setting_q;
		mode_d = mode_q;
		if (do_write) begin
			if (req.addr == `ENC_OFS_PULSE_SETTING) begin
				setting_d = req.wdata[15:0];
			end else if (req.addr == `ENC_OFS_CONTROL) begin
				mode_d = out_mode_t'(req.wdata[`ENC_CTRL_MODE_BIT]);
			end
			// other offsets are read-only or unmapped: writes ignored
		end
	end

	// accumulator: add the step share, emit at most one edge per cycle
	always_comb begin
		inc = step_share(mode_q, setting_q);
		thr = edge_share(mode_q, setting_q);
		sum = acc_q;
		if (enc_step) begin
			if (enc_dir_rev) begin
				sum = acc_q - inc;
			end else begin
				sum = acc_q + inc;
			end
		end
		acc_d = sum;
		step_d = '0;
		if (cfg_write) begin
			// new scaling: drop the pending fraction
			acc_d = '0;
		end else if (sum >= thr) begin
			// one edge forward; each edge is a quarter of an a/b pulse
			acc_d = sum - thr;
			step_d.fwd = 1'b1;
		end else if (sum <= -thr) begin
			// one edge backward
			acc_d = sum + thr;
			step_d.rev = 1'b1;
		end
	end

	// edge count seen by software, wraps at 16 bits
	always_comb begin
		edge_cnt_d = edge_cnt_q;
		if (step_q.fwd) begin
			edge_cnt_d = edge_cnt_q + 16'h0001;
		end else if (step_q.rev) begin
			edge_cnt_d = edge_cnt_q - 16'h0001;
		end
	end

	// register all state
	always_ff @(posedge mclk) begin
		if (srst) begin
			setting_q <= `ENC_SETTING_RESET;
			mode_q <= out_mode_t'(`ENC_CTRL_RESET);
			edge_cnt_q <= 16'h0000;
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			acc_q <= '0;
			step_q <= '0;
		end else begin
			setting_q <= setting_d;
			mode_q <= mode_d;
			edge_cnt_q <= edge_cnt_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			acc_q <= acc_d;
			step_q <= step_d;
		end
	end

	// gray-code generator turns edges into the a/b pair
	quad_phase_gen u_phase (
		.mclk(mclk),
		.srst(srst),
		.step(step_q),
		.phase(phase)
	);

	// outputs: all from flip-flops
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign enc_out = phase;
endmodule

// *** verilog/enc_out_regs.svh ***
// register offsets, field positions, reset values and constants of the encoder pulse output
`ifndef ENC_OUT_REGS_SVH
`define ENC_OUT_REGS_SVH

// byte offsets of the register words on the avalon slave
`define ENC_OFS_PULSE_SETTING 4'h0
`define ENC_OFS_CONTROL 4'h4
`define ENC_OFS_STATUS 4'h8
`define ENC_OFS_EDGE_COUNT 4'hc

// width of the pulse setting register
`define ENC_SETTING_W 16
// pulse setting after reset: 4000 output edges per revolution
`define ENC_SETTING_RESET 16'h0fa0

// control word: bit 0 selects direct count or division ratio
`define ENC_CTRL_MODE_BIT 0
// control word after reset: direct pulse designation
`define ENC_CTRL_RESET 1'h0

// status word: bit 0 phase a, bit 1 phase b
`define ENC_STAT_A_BIT 0
`define ENC_STAT_B_BIT 1

// encoder resolution per motor revolution, in encoder counts
`define ENC_RESOLUTION 24'h00_2710

// width of the signed edge accumulator
`define ENC_ACC_W 24

// number of quadrature edges that make up one a/b pulse period
`define ENC_EDGES_PER_PULSE 3'h4

`endif

// *** verilog/enc_out_pkg.sv ***
// types shared by the encoder pulse output logic
package enc_out_pkg;

	// output mode selected by the control word
	typedef enum logic {
		mode_direct = 1'b0,
		mode_divide = 1'b1
	} out_mode_t;

	// the pair of quadrature phase outputs
	typedef struct packed {
		logic b;
		logic a;
	} quad_t;

	// one request as seen on the register bus
	typedef struct packed {
		logic [3:0] addr;
		logic rd;
		logic wr;
		logic [31:0] wdata;
	} bus_req_t;

	// one step of output motion handed to the phase generator
	typedef struct packed {
		logic fwd;
		logic rev;
	} edge_req_t;

endpackage

// *** verilog/quad_phase_gen.sv ***
// quadrature phase generator: one gray-code step per requested edge
`timescale 1ns/100ps
module quad_phase_gen (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// edge requests from the accumulator
	input enc_out_pkg::edge_req_t step,
	// phase outputs, straight from flip-flops
	output enc_out_pkg::quad_t phase
);
	import enc_out_pkg::*;

	logic [1:0] pos_q; // quadrature position, 0..3
	logic [1:0] pos_d;
	quad_t phase_q; // registered phase pair
	quad_t phase_d;

	// gray code of a quadrature position: a leads b going forward
	function automatic quad_t to_gray(input logic [1:0] p);
		quad_t g;
		g.a = p[1] ^ p[0];
		g.b = p[1];
		return g;
	endfunction

	// next position: forward counts up, reverse counts down
	always_comb begin
		pos_d = pos_q;
		if (step.fwd) begin
			pos_d = pos_q + 2'h1;
		end else if (step.rev) begin
			pos_d = pos_q - 2'h1;
		end
		phase_d = to_gray(pos_d);
	end

	// register position and phase
	always_ff @(posedge mclk) begin
		if (srst) begin
			pos_q <= 2'h0;
			phase_q <= '0;
		end else begin
			pos_q <= pos_d;
			phase_q <= phase_d;
		end
	end

	assign phase = phase_q;
endmodule

// *** dv/enc_out_div_chk.sv ***
// assertions on the encoder pulse output ports
`timescale 1ns/100ps
module enc_out_div_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// register bus
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// motion and phases
	input wire logic enc_step,
	input wire logic enc_dir_rev,
	input enc_out_pkg::quad_t enc_out
);
	import enc_out_pkg::*;
	logic [15:0] set_q, set_d; // shadow of the pulse setting
	logic mode_q, mode_d; // shadow of the mode bit
	logic wr_ok; // write accepted this cycle
	assign wr_ok = avs_write && !avs_waitrequest;
	// follow accepted writes
	always_comb begin
		set_d = set_q;
		mode_d = mode_q;
		if (wr_ok && avs_address == 4'h0) set_d = avs_writedata[15:0];
		if (wr_ok && avs_address == 4'h4) mode_d = avs_writedata[0];
	end
	// shadow registers, reset to direct mode and 4000
	always_ff @(posedge mclk) begin
		set_q <= srst ? 16'h0fa0 : set_d;
		mode_q <= srst ? 1'b0 : mode_d;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	one_edge_a: assert property ($countones(enc_out ^ $past(enc_out)) <= 1)
		else $error("phases moved two bits at once");
	edge_cause_a: assert property (enc_out != $past(enc_out) |-> $past(enc_step, 2))
		else $error("phase edge without a step");
	fwd_gray_a: assert property ($past(enc_step, 2) && !$past(enc_dir_rev, 2) &&
		enc_out != $past(enc_out) |-> enc_out == {$past(enc_out[0]), ~$past(enc_out[1])})
		else $error("forward edge out of order");
	rev_gray_a: assert property ($past(enc_step, 2) && $past(enc_dir_rev, 2) &&
		enc_out != $past(enc_out) |-> enc_out == {~$past(enc_out[0]), $past(enc_out[1])})
		else $error("reverse edge out of order");
	direct_rate_a: assert property (!mode_q && set_q == 16'h2710 && enc_step && !wr_ok
		|-> ##2 enc_out != $past(enc_out)) else $error("direct mode step lost");
	divide_rate_a: assert property (mode_q && set_q == 16'h0001 && enc_step && !wr_ok
		|-> ##2 enc_out != $past(enc_out)) else $error("divide mode step lost");
	setting_rd_a: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0
		|-> avs_readdata == {16'h0000, set_q}) else $error("setting readback wrong");
endmodule

bind encoder_pulse_output_divider enc_out_div_chk chk (.mclk(mclk), .srst(srst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .enc_step(enc_step), .enc_dir_rev(enc_dir_rev),
	.enc_out(enc_out));

// *** dv/quad_host_model.sv ***
// host controller model: counts quadrature edges and a pulses
`timescale 1ns/100ps
module quad_host_model (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// phases in, counts out
	input enc_out_pkg::quad_t enc_out,
	output logic [15:0] pos,
	output logic [15:0] a_rise
);
	import enc_out_pkg::*;
	quad_t prev; // phases one cycle ago
	// decode each gray step into a signed position
	always_ff @(posedge mclk) begin
		prev <= enc_out;
		if (srst) begin
			pos <= 16'h0000;
			a_rise <= 16'h0000;
		end else begin
			if (enc_out == {prev.a, ~prev.b}) pos <= pos + 16'h0001;
			if (enc_out == {~prev.a, prev.b}) pos <= pos - 16'h0001;
			if (enc_out.a && !prev.a) a_rise <= a_rise + 16'h0001;
		end
	end
endmodule

// *** dv/tb_encoder_pulse_output_divider.sv ***
// testbench of the encoder pulse output divider
`timescale 1ns/100ps
module tb_encoder_pulse_output_divider;
	import enc_out_pkg::*;
	logic mclk = 1'b0; // bench clock, driven only by the toggling always block
	logic srst, avs_read, avs_write, avs_waitrequest, enc_step, enc_dir_rev;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdata;
	quad_t enc_out;
	logic [15:0] pos, a_rise, p0, r0;
	int n_errors, total_checks;
	always #10 mclk = ~mclk;
	encoder_pulse_output_divider dut (.mclk(mclk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.enc_step(enc_step), .enc_dir_rev(enc_dir_rev), .enc_out(enc_out));
	quad_host_model hm (.mclk(mclk), .srst(srst), .enc_out(enc_out), .pos(pos),
		.a_rise(a_rise));
	// verdict and end of run
	task complete_run;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// compare one word
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one avalon access, held until waitrequest is seen low
	task bus(input logic w, input logic [3:0] ad, input logic [31:0] wd);
		int i;
		@(posedge mclk);
		avs_address <= ad;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= wd;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 50);
		if (i >= 50) begin
			n_errors++;
			complete_run();
		end
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task rd(input logic [3:0] ad);
		bus(1'b0, ad, 32'h0000_0000);
	endtask
	// n one-cycle steps, gap cycles apart
	task steps(input int n, input logic rev, input int gap);
		repeat (n) begin
			@(posedge mclk);
			enc_step <= 1'b1;
			enc_dir_rev <= rev;
			@(posedge mclk);
			enc_step <= 1'b0;
			repeat (gap - 2) @(posedge mclk);
		end
		repeat (4) @(posedge mclk);
	endtask
	// reset values and an unmapped address
	task t_reset;
		rd(4'h0);
		chk(rdata, 32'h0000_0fa0);
		rd(4'h4);
		chk(rdata, 32'h0000_0000);
		rd(4'h2);
		chk(rdata, 32'h0000_0000);
	endtask
	// default 4000: 1000 steps give 400 edges, 100 pulses
	task t_direct;
		p0 = pos;
		r0 = a_rise;
		steps(1000, 1'b0, 40);
		chk({16'h0000, pos - p0}, 32'h0000_0190);
		chk({16'h0000, a_rise - r0}, 32'h0000_0064);
		rd(4'hc);
		chk({16'h0000, rdata[15:0]}, 32'h0000_0190);
	endtask
	// divide by 8, reverse: 1000 steps give -125 edges
	task t_divide;
		bus(1'b1, 4'h4, 32'h0000_0001);
		bus(1'b1, 4'h0, 32'h0000_0008);
		rd(4'h4);
		chk(rdata, 32'h0000_0001);
		p0 = pos;
		steps(1000, 1'b1, 8);
		chk({16'h0000, pos - p0}, 32'h0000_ff83);
	endtask
	// one edge per step: divide by 1, then direct 10000
	task t_unit;
		bus(1'b1, 4'h0, 32'h0000_0001);
		p0 = pos;
		steps(4, 1'b0, 40);
		bus(1'b1, 4'h4, 32'h0000_0000);
		bus(1'b1, 4'h0, 32'h0000_2710);
		steps(4, 1'b0, 40);
		chk({16'h0000, pos - p0}, 32'h0000_0008);
		rd(4'h8);
		chk(rdata, 32'h0000_0002);
		bus(1'b1, 4'hc, 32'h0000_0000);
		rd(4'hc);
		chk(rdata, 32'h0000_011b);
	endtask
	// a second reset restores the defaults after writes and motion
	task t_reinit;
		@(posedge mclk);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		rd(4'h0);
		chk(rdata, 32'h0000_0fa0);
		rd(4'h4);
		chk(rdata, 32'h0000_0000);
		rd(4'hc);
		chk(rdata, 32'h0000_0000);
		rd(4'h8);
		chk(rdata, 32'h0000_0000);
	endtask
	// reset, then the scenarios
	initial begin
		srst = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		enc_step = 1'b0;
		enc_dir_rev = 1'b0;
		n_errors = 0;
		total_checks = 0;
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		t_reset();
		t_direct();
		t_divide();
		t_unit();
		t_reinit();
		complete_run();
	end
endmodule
